// >>> rtl/rchf_filter.sv
module rchf_filter (
	input wire logic clk, // 125 MHz port receive clock
	input wire logic rst, // async reset, active high
	input wire rchf_pkg::rchf_bus_t bus, // byte register port
	output logic [7:0] reg_rdata, // read data, valid cycle after rd
	input wire logic byte_sync_mode, // line runs byte-synchronous
	input wire logic in_valid, // line byte offered
	input wire logic in_sof, // offered byte is first header byte
	input wire logic [7:0] in_byte, // line byte, MSB first on line
	output logic in_ready, // line byte taken when valid and ready
	output logic out_valid, // fifo byte offered
	output logic [7:0] fifo_byte, // byte toward receive fifo
	input wire logic out_ready // fifo takes byte
);
	rchf_pkg::rchf_regs_t q;
	rchf_pkg::rchf_regs_t d;
	logic acc;
	logic use_dss;
	logic apply;
	logic [50:0] ssd_r;
	logic [38:0] dss_r;
	logic [7:0] clean;
	logic [7:0] push_b;
	logic push_v;
	logic pop;
	logic room;
	logic [1:0] n;
	logic [31:0] hw;
	logic [7:0] syn;
	logic [39:0] fix;
	logic found;
	logic errored;
	logic [31:0] w;
	logic idle;
	logic unas;
	logic inval;
	logic match;
	logic count_hit;
	logic drop;

	function automatic logic [7:0] rev8(input logic [7:0] b);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 8; i++) begin
			r[i] = b[7 - i];
		end
		return r;
	endfunction

	// self-synchronous x^43+1, bit 7 is first on line
	function automatic logic [50:0] ssd_step(input logic [42:0] s, input logic [7:0] b);
		logic [42:0] t;
		logic [7:0] o;
		t = s;
		o = 8'h00;
		for (int i = 7; i >= 0; i--) begin
			o[i] = b[i] ^ t[42];
			t = {t[41:0], b[i]};
		end
		return {t, o};
	endfunction

	// distributed-sample x^31+x^28+1 generator
	function automatic logic [38:0] dss_step(input logic [30:0] g, input logic [7:0] b);
		logic [30:0] t;
		logic [7:0] o;
		t = g;
		o = 8'h00;
		for (int i = 7; i >= 0; i--) begin
			o[i] = b[i] ^ t[30];
			t = {t[29:0], t[30] ^ t[rchf_pkg::DSS_TAP]};
		end
		return {t, o};
	endfunction

	function automatic logic [7:0] hec_calc(input logic [31:0] h, input logic span3);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 31; i >= 0; i--) begin
			if (!span3 || i < 24) begin
				c = {c[6:0], 1'b0} ^ ((c[7] ^ h[i]) ? rchf_pkg::HEC_POLY : 8'h00);
			end
		end
		return c;
	endfunction

	always_comb begin
		logic [39:0] oh;
		logic [7:0] es;
		logic [7:0] b0;
		logic [7:0] b1;
		logic ready_st;
		oh = 40'h0;
		es = 8'h00;
		b0 = 8'h00;
		b1 = 8'h00;
		ready_st = 1'b0;
		d = q;
		acc = in_valid && q.in_ready;
		use_dss = q.ctrl_b[rchf_pkg::CB_DSS] && !byte_sync_mode &&
			!q.ctrl_a[rchf_pkg::CA_CLEAR];
		ssd_r = ssd_step(q.ssd, in_byte);
		dss_r = dss_step(q.distributed_sample_scrambling, in_byte);
		apply = !q.ctrl_a[rchf_pkg::CA_DESCR_OFF] && (q.ctrl_a[rchf_pkg::CA_CLEAR] ||
			q.st != rchf_pkg::ST_HDR || (q.ctrl_a[rchf_pkg::CA_HDR_DESCR] && !use_dss));
		clean = apply ? (use_dss ? dss_r[7:0] : ssd_r[7:0]) : in_byte;
		if (acc && !q.ctrl_a[rchf_pkg::CA_DESCR_OFF]) begin
			if (use_dss) begin
				d.distributed_sample_scrambling = dss_r[38:8];
			end else begin
				d.ssd = ssd_r[50:8];
			end
		end

		// header check, correction and filters on the collected header
		hw = q.hdr[39:8];
		syn = hec_calc(hw, q.ctrl_b[rchf_pkg::CB_DUAL]) ^ q.hdr[7:0] ^
			(q.ctrl_a[rchf_pkg::CA_COSET_OFF] ? 8'h00 : rchf_pkg::HEC_COSET);
		fix = 40'h0;
		found = 1'b0;
		if (syn != 8'h00 && !q.ctrl_a[rchf_pkg::CA_FIX_OFF]) begin
			for (int i = 0; i < 40; i++) begin
				oh = 40'h1 << i;
				es = (i < 8) ? oh[7:0] : hec_calc(oh[39:8], q.ctrl_b[rchf_pkg::CB_DUAL]);
				if (!found && es == syn) begin
					fix = oh;
					found = 1'b1;
				end
			end
		end
		errored = syn != 8'h00 && !found;
		w = hw ^ fix[39:8];
		idle = w == rchf_pkg::IDLE_HDR;
		unas = (w & rchf_pkg::UNASSIGNED_MASK) == 32'h0;
		inval = !idle && !unas && (w & rchf_pkg::INVALID_MASK) == 32'h0;
		match = ((w ^ q.pat) & ~q.mask) == 32'h0;
		count_hit = q.ctrl_b[rchf_pkg::CB_MODE_LO] ? !match : match;
		drop = (errored && !q.ctrl_b[rchf_pkg::CB_ERR_OFF]) ||
			(!errored && idle && !q.ctrl_b[rchf_pkg::CB_IDLE_OFF]) ||
			(!errored && unas && q.ctrl_b[rchf_pkg::CB_UNASSIGNED_EN]) ||
			(!errored && inval && q.ctrl_b[rchf_pkg::CB_INVALID_EN]) ||
			(!errored && q.ctrl_b[rchf_pkg::CB_MODE_LO + 1] && count_hit);

		pop = q.out_valid && out_ready;
		room = pop || q.cnt != 2'h2;
		push_v = 1'b0;
		push_b = 8'h00;
		unique case (q.st)
			rchf_pkg::ST_HDR: begin
				if (acc && q.ctrl_a[rchf_pkg::CA_CLEAR]) begin
					push_v = 1'b1;
					push_b = clean;
				end else if (acc && (in_sof || q.hcnt != 3'h0)) begin
					d.hdr = {q.hdr[31:0], clean};
					d.hcnt = 3'(q.hcnt + 3'h1);
					if (q.hcnt == rchf_pkg::HDR_LAST) begin
						d.st = rchf_pkg::ST_DECIDE;
					end
				end
			end
			rchf_pkg::ST_DECIDE: begin
				d.hdr = q.hdr ^ fix;
				d.hcnt = 3'h0;
				d.pcnt = rchf_pkg::PAYLOAD_BYTES;
				d.st = drop ? rchf_pkg::ST_DROP : rchf_pkg::ST_EMIT;
				if (errored) begin
					d.err_cnt = 24'(q.err_cnt + 24'h1);
				end
				if (!errored && count_hit) begin
					d.pat_cnt = 24'(q.pat_cnt + 24'h1);
				end
				if (!errored && unas && q.ctrl_b[rchf_pkg::CB_UNASSIGNED_EN]) begin
					d.filt_cnt = 24'(q.filt_cnt + 24'h1);
				end
			end
			rchf_pkg::ST_EMIT: begin
				if (room) begin
					push_v = 1'b1;
					push_b = q.hdr[39:32];
					d.hdr = {q.hdr[31:0], 8'h00};
					d.hcnt = 3'(q.hcnt + 3'h1);
					if (q.hcnt == rchf_pkg::HDR_LAST) begin
						d.hcnt = 3'h0;
						d.st = rchf_pkg::ST_PAY;
					end
				end
			end
			rchf_pkg::ST_PAY, rchf_pkg::ST_DROP: begin
				if (acc) begin
					push_v = q.st == rchf_pkg::ST_PAY;
					push_b = clean;
					d.pcnt = 6'(q.pcnt - 6'h1);
					if (q.pcnt == 6'h1) begin
						d.st = rchf_pkg::ST_HDR;
					end
				end
			end
		endcase

		// two-entry buffer toward the fifo
		n = q.cnt;
		b0 = q.buf0;
		b1 = q.buf1;
		if (pop) begin
			b0 = q.buf1;
			n = 2'(q.cnt - 2'h1);
		end
		if (push_v) begin
			if (n == 2'h0) begin
				b0 = q.ctrl_a[rchf_pkg::CA_REORDER] ? rev8(push_b) : push_b;
			end else begin
				b1 = q.ctrl_a[rchf_pkg::CA_REORDER] ? rev8(push_b) : push_b;
			end
			n = 2'(n + 2'h1);
		end
		d.cnt = n;
		d.buf0 = b0;
		d.buf1 = b1;
		d.out_valid = n != 2'h0;
		ready_st = d.st == rchf_pkg::ST_HDR || d.st == rchf_pkg::ST_PAY ||
			d.st == rchf_pkg::ST_DROP;
		d.in_ready = ready_st && n != 2'h2;

		if (bus.wr) begin
			unique case (bus.addr)
				rchf_pkg::ADDR_CTRL_A: d.ctrl_a = bus.wdata;
				rchf_pkg::ADDR_CTRL_B: d.ctrl_b = bus.wdata;
				rchf_pkg::ADDR_PAT_0: d.pat[7:0] = bus.wdata;
				rchf_pkg::ADDR_PAT_1: d.pat[15:8] = bus.wdata;
				rchf_pkg::ADDR_PAT_2: d.pat[23:16] = bus.wdata;
				rchf_pkg::ADDR_PAT_3: d.pat[31:24] = bus.wdata;
				rchf_pkg::ADDR_MASK_0: d.mask[7:0] = bus.wdata;
				rchf_pkg::ADDR_MASK_1: d.mask[15:8] = bus.wdata;
				rchf_pkg::ADDR_MASK_2: d.mask[23:16] = bus.wdata;
				rchf_pkg::ADDR_MASK_3: d.mask[31:24] = bus.wdata;
				default: ;
			endcase
		end
		if (bus.rd) begin
			unique case (bus.addr)
				rchf_pkg::ADDR_CTRL_A: d.rdata = q.ctrl_a;
				rchf_pkg::ADDR_CTRL_B: d.rdata = q.ctrl_b;
				rchf_pkg::ADDR_PAT_0: d.rdata = q.pat[7:0];
				rchf_pkg::ADDR_PAT_1: d.rdata = q.pat[15:8];
				rchf_pkg::ADDR_PAT_2: d.rdata = q.pat[23:16];
				rchf_pkg::ADDR_PAT_3: d.rdata = q.pat[31:24];
				rchf_pkg::ADDR_MASK_0: d.rdata = q.mask[7:0];
				rchf_pkg::ADDR_MASK_1: d.rdata = q.mask[15:8];
				rchf_pkg::ADDR_MASK_2: d.rdata = q.mask[23:16];
				rchf_pkg::ADDR_MASK_3: d.rdata = q.mask[31:24];
				rchf_pkg::ADDR_STATUS: d.rdata = {5'h00, q.err_cnt != 24'h0,
					q.pat_cnt != 24'h0, 1'b0};
				rchf_pkg::ADDR_ERR_CNT: d.rdata = q.err_cnt[7:0];
				rchf_pkg::ADDR_ERR_CNT + 16'h1: d.rdata = q.err_cnt[15:8];
				rchf_pkg::ADDR_ERR_CNT + 16'h2: d.rdata = q.err_cnt[23:16];
				rchf_pkg::ADDR_PAT_CNT: d.rdata = q.pat_cnt[7:0];
				rchf_pkg::ADDR_PAT_CNT + 16'h1: d.rdata = q.pat_cnt[15:8];
				rchf_pkg::ADDR_PAT_CNT + 16'h2: d.rdata = q.pat_cnt[23:16];
				rchf_pkg::ADDR_FILT_CNT: d.rdata = q.filt_cnt[7:0];
				rchf_pkg::ADDR_FILT_CNT + 16'h1: d.rdata = q.filt_cnt[15:8];
				rchf_pkg::ADDR_FILT_CNT + 16'h2: d.rdata = q.filt_cnt[23:16];
				default: d.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= '0;
			q.st <= rchf_pkg::ST_HDR;
			q.ctrl_a <= rchf_pkg::CTRL_RESET;
			q.ctrl_b <= rchf_pkg::CTRL_RESET;
			q.distributed_sample_scrambling <= rchf_pkg::DSS_SEED;
		end else begin
			q <= d;
		end
	end

	assign reg_rdata = q.rdata;
	assign in_ready = q.in_ready;
	assign out_valid = q.out_valid;
	assign fifo_byte = q.buf0;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_decide_keep;
		q.st == rchf_pkg::ST_DECIDE && !drop;
	endsequence
	sequence s_header_out;
		q.st == rchf_pkg::ST_EMIT ##[1:300] q.st == rchf_pkg::ST_PAY;
	endsequence

	a_kept_cell_emits: assert property (
		s_decide_keep |=> s_header_out
	) else $error("kept cell header not emitted");
	a_reorder_order: assert property (
		acc && q.st == rchf_pkg::ST_HDR && q.ctrl_a[rchf_pkg::CA_CLEAR] &&
		q.ctrl_a[rchf_pkg::CA_DESCR_OFF] && q.cnt == 2'h0 && !pop
		|=> q.buf0 == (q.ctrl_a[rchf_pkg::CA_REORDER] ? rev8($past(in_byte)) : $past(in_byte))
	) else $error("fifo byte bit order wrong");
	a_descr_skip: assert property (
		acc && q.ctrl_a[rchf_pkg::CA_DESCR_OFF] |-> clean == in_byte ##1 $stable(q.ssd)
	) else $error("descrambling while disabled");
	a_hdr_plain: assert property (
		acc && q.st == rchf_pkg::ST_HDR && !q.ctrl_a[rchf_pkg::CA_CLEAR] &&
		!q.ctrl_a[rchf_pkg::CA_HDR_DESCR] |-> clean == in_byte
	) else $error("header descrambled with header descramble off");
	a_dss_forced_off: assert property (
		(byte_sync_mode || q.ctrl_a[rchf_pkg::CA_CLEAR]) && acc |=> $stable(q.distributed_sample_scrambling)
	) else $error("distributed-sample used in forced self-sync mode");
	a_err_extract: assert property (
		q.st == rchf_pkg::ST_DECIDE && errored && !q.ctrl_b[rchf_pkg::CB_ERR_OFF]
		|=> q.st == rchf_pkg::ST_DROP ##0 q.err_cnt == $past(q.err_cnt) + 24'h1
	) else $error("errored cell not extracted");
	a_idle_drop: assert property (
		q.st == rchf_pkg::ST_DECIDE && !errored && idle && !q.ctrl_b[rchf_pkg::CB_IDLE_OFF]
		|=> q.st == rchf_pkg::ST_DROP
	) else $error("idle cell passed");
	a_unas_count: assert property (
		q.st == rchf_pkg::ST_DECIDE && !errored && unas &&
		q.ctrl_b[rchf_pkg::CB_UNASSIGNED_EN]
		|=> q.st == rchf_pkg::ST_DROP && q.filt_cnt == $past(q.filt_cnt) + 24'h1
	) else $error("unassigned cell not counted and dropped");
	a_inval_drop: assert property (
		q.st == rchf_pkg::ST_DECIDE && !errored && inval && q.ctrl_b[rchf_pkg::CB_INVALID_EN]
		|=> q.st == rchf_pkg::ST_DROP
	) else $error("invalid cell passed");
	a_cmp_mode: assert property (
		q.st == rchf_pkg::ST_DECIDE && !errored &&
		(((q.hdr[39:8] ^ q.pat) & ~q.mask) == 32'h0) == !q.ctrl_b[rchf_pkg::CB_MODE_LO]
		|=> q.pat_cnt == $past(q.pat_cnt) + 24'h1 &&
		(!$past(q.ctrl_b[rchf_pkg::CB_MODE_LO + 1]) || q.st == rchf_pkg::ST_DROP)
	) else $error("pattern compare mode misbehaves");
	a_fix_off: assert property (
		q.st == rchf_pkg::ST_DECIDE && q.ctrl_a[rchf_pkg::CA_FIX_OFF] && syn != 8'h00
		|-> errored
	) else $error("correction while disabled");
endmodule

// >>> rtl/rchf_pkg.sv
// How it works
// - header-descramble clear means payload only; set means header and payload descrambled
// - header-descramble bit ignored when descrambling off or distributed-sample selected
// - clear channel with descrambling on descrambles every byte of the stream
// - descramble-off at 0 descrambles; at 1 skips descrambling completely
// - reorder off puts first bit in fifo byte MSB; on puts it in LSB
// - clear channel bypasses all cell processing except descrambling and bit reordering
// - descramble type 0 is self-synchronous, 1 distributed-sample; ignored when descrambling off
// - byte-synchronous and clear-channel modes always use self-synchronous descrambling
// - header check over four header bytes, or last three when dual-bus span set
// - errored header cells removed unless errored-extract-off is set
// - compare mode 00 count match, 01 count miss, 10/11 also discard
// - idle cells discarded unless idle-filter-off is set
// - unassigned filter enable set counts and drops unassigned cells, else passes them
// - invalid filter enable set drops invalid cells, else forwards them
// - 32-bit header pattern held as four byte registers, low byte first
// - set mask bit makes that header bit a don't-care in the compare
// - single-bit header errors corrected unless correction off; then all errors uncorrectable
// - coset added to computed check before comparing, unless coset addition off
package rchf_pkg;
	localparam logic [15:0] ADDR_CTRL_A = 16'h1000;
	localparam logic [15:0] ADDR_CTRL_B = 16'h1001;
	localparam logic [15:0] ADDR_PAT_0 = 16'h1004;
	localparam logic [15:0] ADDR_PAT_1 = 16'h1005;
	localparam logic [15:0] ADDR_PAT_2 = 16'h1006;
	localparam logic [15:0] ADDR_PAT_3 = 16'h1007;
	localparam logic [15:0] ADDR_MASK_0 = 16'h1008;
	localparam logic [15:0] ADDR_MASK_1 = 16'h1009;
	localparam logic [15:0] ADDR_MASK_2 = 16'h100A;
	localparam logic [15:0] ADDR_MASK_3 = 16'h100B;
	localparam logic [15:0] ADDR_STATUS = 16'h100E;
	localparam logic [15:0] ADDR_ERR_CNT = 16'h1018;
	localparam logic [15:0] ADDR_PAT_CNT = 16'h101C;
	localparam logic [15:0] ADDR_FILT_CNT = 16'h1024;
	localparam int CA_CLEAR = 0;
	localparam int CA_REORDER = 1;
	localparam int CA_DESCR_OFF = 2;
	localparam int CA_HDR_DESCR = 3;
	localparam int CA_FIX_OFF = 4;
	localparam int CA_COSET_OFF = 5;
	localparam int CB_INVALID_EN = 0;
	localparam int CB_UNASSIGNED_EN = 1;
	localparam int CB_IDLE_OFF = 2;
	localparam int CB_MODE_LO = 3;
	localparam int CB_ERR_OFF = 5;
	localparam int CB_DUAL = 6;
	localparam int CB_DSS = 7;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [2:0] HDR_LAST = 3'h4;
	localparam logic [5:0] PAYLOAD_BYTES = 6'h30;
	localparam logic [7:0] HEC_POLY = 8'h07;
	localparam logic [7:0] HEC_COSET = 8'h55;
	localparam logic [31:0] IDLE_HDR = 32'h00000001;
	localparam logic [31:0] UNASSIGNED_MASK = 32'hFFFFFFF1;
	localparam logic [31:0] INVALID_MASK = 32'h0FFFFFF0;
	localparam logic [30:0] DSS_SEED = 31'h7FFFFFFF;
	localparam int DSS_TAP = 27;
	typedef enum logic [2:0] {ST_HDR, ST_DECIDE, ST_EMIT, ST_PAY, ST_DROP} rchf_state_t;
	typedef enum logic [1:0] {CMP_COUNT_MATCH, CMP_COUNT_MISS, CMP_DROP_MATCH, CMP_DROP_MISS} rchf_cmp_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [7:0] wdata;
	} rchf_bus_t;
	typedef struct packed {
		rchf_state_t st;
		logic [7:0] ctrl_a;
		logic [7:0] ctrl_b;
		logic [31:0] pat;
		logic [31:0] mask;
		logic [23:0] err_cnt;
		logic [23:0] pat_cnt;
		logic [23:0] filt_cnt;
		logic [7:0] rdata;
		logic [42:0] ssd;
		logic [30:0] distributed_sample_scrambling;
		logic [39:0] hdr;
		logic [2:0] hcnt;
		logic [5:0] pcnt;
		logic [1:0] cnt;
		logic [7:0] buf0;
		logic [7:0] buf1;
		logic in_ready;
		logic out_valid;
	} rchf_regs_t;
endpackage

// >>> verification/rchf_sink.sv
module rchf_sink (
	input wire logic clk, // port clock
	input wire logic rst, // async reset, active high
	input wire logic out_valid, // byte offered by block
	input wire logic [7:0] fifo_byte, // offered byte
	input wire logic hold, // stall completely
	input wire logic slow, // stall one cycle in three
	output logic out_ready // byte taken this cycle
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] cnt;
	logic [7:0] got[$];
	assign out_ready = !hold && !(slow && cnt == 2'h2);
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= 2'h0;
		end else begin
			if (out_valid && out_ready) begin
				got.push_back(fifo_byte);
			end
			cnt <= #1 (cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
		end
	end
endmodule

// >>> verification/rx_cell_header_filter_test.sv
module rx_cell_header_filter_test;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [7:0] ca;
		logic [7:0] cb;
		logic [31:0] hdr;
		logic [7:0] x;
		logic [5:0] pad;
		logic pass;
		logic raw;
	} rchf_row_t;
	logic clk, rst, in_valid, in_sof, in_ready, out_valid, out_ready, hold, slow, scr, rev;
	logic byte_sync;
	logic [7:0] reg_rdata, in_byte, fifo_byte;
	logic [7:0] exp_q[$];
	logic [42:0] h;
	rchf_pkg::rchf_bus_t bus;
	int error_cnt, n_checks;
	rchf_filter i_dut (.clk(clk), .rst(rst), .bus(bus), .reg_rdata(reg_rdata),
		.byte_sync_mode(byte_sync), .in_valid(in_valid), .in_sof(in_sof), .in_byte(in_byte),
		.in_ready(in_ready), .out_valid(out_valid), .fifo_byte(fifo_byte),
		.out_ready(out_ready));
	rchf_sink i_sink (.clk(clk), .rst(rst), .out_valid(out_valid), .fifo_byte(fifo_byte),
		.hold(hold), .slow(slow), .out_ready(out_ready));
	always #4 clk = ~clk;
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk8(input logic [7:0] g, input logic [7:0] e, input string m);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task automatic chk1(input logic g, input logic e, input string m);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		bus = '{1'b1, 1'b0, a, d};
		@(posedge clk);
		#1;
		bus.wr = 1'b0;
		@(posedge clk);
		#1;
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		bus = '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk);
		#1;
		bus.rd = 1'b0;
		@(posedge clk);
		#1;
		d = reg_rdata;
	endtask
	task automatic send(input logic [7:0] b, input logic sof);
		int n;
		n = 0;
		in_valid = 1'b1;
		in_byte = b;
		in_sof = sof;
		while (!in_ready && n < 200) begin
			@(posedge clk);
			#1;
			n++;
		end
		@(posedge clk);
		#1;
	endtask
	task automatic idle();
		in_valid = 1'b0;
	endtask
	function automatic logic [7:0] hec(input logic [31:0] w, input logic dual);
		logic [7:0] c;
		c = 8'h00;
		for (int i = (dual ? 1 : 0); i < 4; i++) begin
			c ^= w[31-8*i -: 8];
			for (int k = 0; k < 8; k++) begin
				c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
			end
		end
		return c ^ 8'h55;
	endfunction
	// self-synchronous descrambler model, history of sent line bits
	task automatic put(input logic [7:0] b, input logic [7:0] e, input logic sof, input logic pay);
		logic [7:0] o;
		for (int k = 7; k >= 0; k--) begin
			o[k] = e[k] ^ (scr && pay && h[42]);
			if (scr) begin
				h = {h[41:0], b[k]};
			end
		end
		exp_q.push_back(rev ? {<<{o}} : o);
		send(b, sof);
	endtask
	task automatic run_cell(input rchf_row_t r, input string m);
		logic [39:0] c;
		logic [7:0] s;
		int n;
		c = {r.hdr, hec(r.hdr, r.cb[6])};
		wr(16'h1000, r.ca);
		wr(16'h1001, r.cb);
		scr = !r.ca[2];
		rev = r.ca[1];
		i_sink.got.delete();
		exp_q.delete();
		for (int i = 0; i < 5; i++) begin
			s = c[39-8*i -: 8] ^ ((i == 4) ? r.x : 8'h00);
			put(s, r.raw ? s : c[39-8*i -: 8], i == 0, 1'b0);
		end
		for (int i = 0; i < 48; i++) begin
			put(8'(i * 5 + 3), 8'(i * 5 + 3), 1'b0, 1'b1);
		end
		idle();
		if (!r.pass) begin
			exp_q.delete();
		end
		n = 0;
		while (i_sink.got.size() < exp_q.size() && n < 400) begin
			@(posedge clk);
			n++;
		end
		repeat (20) @(posedge clk);
		#1;
		chk8(8'(i_sink.got.size()), 8'(exp_q.size()), m);
		foreach (exp_q[i]) chk8(i_sink.got[i], exp_q[i], m);
	endtask
	task automatic t_regs();
		logic [15:0] a[8] = '{16'h1000, 16'h1001, 16'h1004, 16'h1005, 16'h1006, 16'h1007,
			16'h1008, 16'h1009};
		logic [7:0] d;
		foreach (a[i]) begin
			rd(a[i], d);
			chk8(d, 8'h00, "reset value");
			wr(a[i], a[i][7:0] ^ 8'h5A);
			rd(a[i], d);
			chk8(d, a[i][7:0] ^ 8'h5A, "readback");
			wr(a[i], 8'h00);
		end
		wr(16'h1002, 8'hFF);
		rd(16'h1002, d);
		chk8(d, 8'h00, "unmapped read");
		$display("test regs done");
	endtask
	task automatic t_descr();
		run_cell(64'h0000_12345670_0003, "payload descramble");
		byte_sync = 1'b1;
		run_cell(64'h0080_12345670_0003, "byte sync forces self-sync");
		byte_sync = 1'b0;
		$display("test descr done");
	endtask
	task automatic t_clear();
		logic [7:0] b[6] = '{8'h01, 8'h80, 8'hC3, 8'h5A, 8'h0F, 8'hF0};
		wr(16'h1000, 8'h07);
		hold = 1'b1;
		slow = 1'b0;
		scr = 1'b0;
		rev = 1'b1;
		i_sink.got.delete();
		exp_q.delete();
		fork
			begin
				foreach (b[i]) put(b[i], b[i], 1'b0, 1'b1);
				idle();
			end
			begin
				repeat (12) @(posedge clk);
				#1;
				chk1(in_ready, 1'b0, "buffer full refuses");
				hold = 1'b0;
			end
		join
		repeat (10) @(posedge clk);
		#1;
		foreach (b[i]) chk8(i_sink.got[i], exp_q[i], "clear reorder");
		chk8(8'(i_sink.got.size()), 8'h06, "clear count");
		chk1(out_valid, 1'b0, "buffer drained");
		slow = 1'b1;
		$display("test clear done");
	endtask
	task automatic t_clear_scr();
		logic [7:0] b[6] = '{8'h01, 8'h80, 8'hC3, 8'h5A, 8'h0F, 8'hF0};
		wr(16'h1000, 8'h03);
		scr = 1'b1;
		rev = 1'b1;
		i_sink.got.delete();
		exp_q.delete();
		foreach (b[i]) put(b[i], b[i], 1'b0, 1'b1);
		idle();
		repeat (20) @(posedge clk);
		#1;
		chk8(8'(i_sink.got.size()), 8'h06, "clear descramble count");
		foreach (b[i]) chk8(i_sink.got[i], exp_q[i], "clear descramble");
		$display("test clear scramble done");
	endtask
	task automatic t_filters();
		logic [63:0] t[14] = '{64'h0400_12345670_0003, 64'h0400_00000001_0001,
			64'h0404_00000001_0003, 64'h0400_00000000_0003, 64'h0402_00000000_0001,
			64'h0400_10000000_0003, 64'h0401_10000000_0001, 64'h0400_12345670_0301,
			64'h0420_12345670_0303, 64'h0400_12345670_0102, 64'h1400_12345670_0101,
			64'h2400_12345670_5503, 64'h0440_12345670_0003, 64'h0400_12345670_5501};
		foreach (t[i]) run_cell(t[i], "filter");
		$display("test filters done");
	endtask
	task automatic t_compare();
		logic [63:0] t[8] = '{64'h0400_12345670_0003, 64'h0408_12345670_0003,
			64'h0408_12345671_0003, 64'h0410_12345670_0001, 64'h0410_12345671_0003,
			64'h0418_12345670_0003, 64'h0418_12345671_0001, 64'h0410_12345671_0001};
		logic [31:0] p = 32'h12345670;
		logic [7:0] c0, c1;
		for (int i = 0; i < 4; i++) begin
			wr(16'h1004 + 16'(i), p[8*i +: 8]);
		end
		rd(16'h101C, c0);
		foreach (t[i]) begin
			if (i == 7) begin
				wr(16'h1008, 8'h01);
			end
			run_cell(t[i], "compare");
		end
		rd(16'h101C, c1);
		chk8(c1, c0 + 8'h05, "pattern count");
		$display("test compare done");
	endtask
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		bus = '0;
		in_valid = 1'b0;
		in_sof = 1'b0;
		in_byte = 8'h00;
		hold = 1'b0;
		slow = 1'b1;
		h = '0;
		byte_sync = 1'b0;
		scr = 1'b0;
		rev = 1'b0;
		error_cnt = 0;
		n_checks = 0;
		repeat (10) @(posedge clk);
		#1;
		rst = 1'b0;
		@(posedge clk);
		#1;
		t_regs();
		t_descr();
		t_clear();
		t_clear_scr();
		t_filters();
		t_compare();
		finish_test();
	end
	initial begin
		repeat (30000) @(posedge clk);
		error_cnt++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		finish_test();
	end
endmodule
